// ===== tevcg_pkg.sv
`default_nettype none
package tevcg_pkg;

	// ************************************************************
	// Sizes
	// ************************************************************
	localparam int unsigned NUM_CNT = 3; // Counters in the group
	localparam int unsigned DIV_W = 7; // Prescaler chain, up to /128

	// ************************************************************
	// Register map
	// ************************************************************
	localparam logic [3:0] ADDR_CTRL0 = 4'h0; // First control register
	localparam logic [3:0] ADDR_DATA0 = 4'h1; // First preload/count
	localparam logic [3:0] ADDR_STEP = 4'h2; // Distance between counters
	localparam logic [3:0] ADDR_FLAG = 4'h6; // Overflow request flags
	localparam logic [3:0] ADDR_IEN = 4'h7; // Interrupt enables

	// ************************************************************
	// Control fields
	// ************************************************************
	localparam int unsigned RUN_BIT = 4; // Count enable
	localparam int unsigned EDGE_BIT = 3; // Active edge select
	localparam logic [1:0] MODE_ONESHOT = 2'h0; // Counter 1 only
	localparam logic [1:0] MODE_EVENT = 2'h1; // Counter 0 only
	localparam logic [1:0] MODE_TIMER = 2'h2; // All counters
	localparam logic [1:0] MODE_PULSE = 2'h3; // Counter 0 only
	localparam logic [7:0] CTRL_MASK0 = 8'hff; // Implemented bits
	localparam logic [7:0] CTRL_MASK1 = 8'hd7;
	localparam logic [7:0] CTRL_MASK2 = 8'h17;

	// ************************************************************
	// Reset values and limits
	// ************************************************************
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] PRELOAD_RESET = 8'h00;
	localparam logic [7:0] COUNT_RESET = 8'h00;
	localparam logic [7:0] COUNT_FULL = 8'hff;
	localparam logic [6:0] PSC_RESET = 7'h00;

	// Control register layout
	typedef struct packed {
		logic [1:0] mode; // Operating mode
		logic src; // Counter 0 source: 0 pin, 1 irq0 signal
		logic run; // Count enable
		logic edge_sel; // Active edge select
		logic [2:0] div; // Prescaler select
	} tevcg_ctrl_t;

	// Register port request
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} tevcg_bus_t;

	// Pulse width capture progress
	typedef enum logic {PW_WAIT, PW_MEASURE} tevcg_pw_t;

endpackage
`default_nettype wire

// ===== tevcg_prescale.sv
`timescale 1ns/1ns
`default_nettype none
module tevcg_prescale
(
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic [2:0] div,
	output logic tick
);
	import tevcg_pkg::*;

	// ************************************************************
	// Free running divider chain
	// ************************************************************
	logic [DIV_W-1:0] cnt_q; // Divider chain
	logic [DIV_W-1:0] mask; // Low bits that must be all ones

	// Chain advances every cycle
	always_ff @(posedge mclk)
	begin
		if (!reset_n)
			cnt_q <= PSC_RESET;
		else
			cnt_q <= cnt_q + 7'h01;
	end

	// Tick marks the falling edge of the divided clock
	always_comb
	begin
		mask = DIV_W'((8'h01 << div) - 8'h01);
		tick = &(cnt_q | ~mask);
	end

	// ************************************************************
	// Checks
	// ************************************************************
	chk_div_bypass: assert property (@(posedge mclk) disable iff (!reset_n)
		div == 3'h0 |-> tick)
		else $error("undivided prescaler missed a tick");
	chk_div_spacing: assert property (@(posedge mclk) disable iff (!reset_n)
		div != 3'h0 && tick && $stable(div) |=> !tick || div == 3'h0)
		else $error("divided prescaler ticked twice in a row");

endmodule // tevcg_prescale
`default_nettype wire

// ===== tevcg_edge.sv
`timescale 1ns/1ns
`default_nettype none
module tevcg_edge
(
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic sig,
	output logic rise,
	output logic fall
);
	import tevcg_pkg::*;

	logic prev_q; // Level seen one cycle earlier

	// Remember the last level
	always_ff @(posedge mclk)
	begin
		if (!reset_n)
			prev_q <= 1'b0;
		else
			prev_q <= sig;
	end

	// Transition pulses, one cycle each
	assign rise = sig & ~prev_q;
	assign fall = ~sig & prev_q;

	chk_edge_excl: assert property (@(posedge mclk) disable iff (!reset_n)
		rise |-> !fall ##1 !rise)
		else $error("edge detector gave overlapping pulses");

endmodule // tevcg_edge
`default_nettype wire

// ===== tevcg_top.sv
// The address-and-strobe port and the register offsets were decided locally.
`timescale 1ns/1ns
`default_nettype none
module tevcg_top
(
	input wire logic mclk,
	input wire logic reset_n,
	input wire tevcg_pkg::tevcg_bus_t bus,
	output logic [7:0] rdata,
	input wire logic counter0_input_pin,
	input wire logic external_irq0_signal,
	input wire logic pulse_generator_stop,
	output logic [2:0] irq_req,
	output logic wake_up
);
	import tevcg_pkg::*;

	// ************************************************************
	// Shared state
	// ************************************************************
	tevcg_ctrl_t ctrl_q [NUM_CNT]; // Control registers
	logic [7:0] preload_q [NUM_CNT]; // Preload registers
	logic [7:0] count_q [NUM_CNT]; // Live counts
	logic [NUM_CNT-1:0] flag_q; // Sticky overflow requests
	logic [NUM_CNT-1:0] ien_q; // Interrupt enables
	logic [7:0] rdata_q; // Read data, one cycle late
	logic wake_q; // Wake-up pulse
	tevcg_pw_t pw_q; // Counter 0 capture progress
	logic [NUM_CNT-1:0] tick; // Prescaled falling edges
	logic [NUM_CNT-1:0] wr_ctrl; // Control write strobes
	logic [NUM_CNT-1:0] wr_data; // Preload write strobes
	logic [NUM_CNT-1:0] inc; // Count this cycle
	logic [NUM_CNT-1:0] ovf; // Overflow this cycle
	logic [NUM_CNT-1:0] hw_set; // Hardware sets enable
	logic [NUM_CNT-1:0] hw_clr; // Hardware clears enable
	logic ext_sig; // Counter 0 external source
	logic ext_rise; // Source low to high
	logic ext_fall; // Source high to low
	logic pw_start; // Active edge seen while waiting
	logic pw_end; // Return edge seen while measuring
	logic wr_flag; // Flag register write

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!reset_n);

	// Implemented control bits for a counter
	function automatic logic [7:0] ctrl_mask(input int unsigned idx);
		ctrl_mask = (idx == 0) ? CTRL_MASK0 :
			(idx == 1) ? CTRL_MASK1 : CTRL_MASK2;
	endfunction

	// Control address of a counter
	function automatic logic [3:0] ctrl_addr(input int unsigned idx);
		ctrl_addr = ADDR_CTRL0 + 4'(idx) * ADDR_STEP;
	endfunction

	// Effective mode; counter 2 has no mode field
	function automatic logic [1:0] eff_mode(input int unsigned idx,
		input tevcg_ctrl_t c);
		eff_mode = (idx == 2) ? MODE_TIMER : c.mode;
	endfunction

	// ************************************************************
	// Counter 0 external input
	// ************************************************************
	// Pin or irq0 signal, no prescaler in between
	assign ext_sig = ctrl_q[0].src ? external_irq0_signal
		: counter0_input_pin;

	tevcg_edge u_edge
	(
		.mclk(mclk),
		.reset_n(reset_n),
		.sig(ext_sig),
		.rise(ext_rise),
		.fall(ext_fall)
	);

	// Active edge opens, opposite edge closes the capture
	always_comb
	begin
		pw_start = 1'b0;
		pw_end = 1'b0;
		if (ctrl_q[0].mode == MODE_PULSE && ctrl_q[0].run)
		begin
			if (pw_q == PW_WAIT)
				pw_start = ctrl_q[0].edge_sel ? ext_rise : ext_fall;
			else
				pw_end = ctrl_q[0].edge_sel ? ext_fall : ext_rise;
		end
	end

	// Capture progress, reset whenever disabled or mode left
	always_ff @(posedge mclk)
	begin
		if (!reset_n)
			pw_q <= PW_WAIT;
		else if (!ctrl_q[0].run || ctrl_q[0].mode != MODE_PULSE)
			pw_q <= PW_WAIT;
		else
		begin
			unique case (pw_q)
				PW_WAIT:
					if (pw_start)
						pw_q <= PW_MEASURE;
				PW_MEASURE:
					if (pw_end)
						pw_q <= PW_WAIT;
			endcase
		end
	end

	// ************************************************************
	// Register decode
	// ************************************************************
	assign wr_flag = bus.wr && bus.addr == ADDR_FLAG;

	// ************************************************************
	// Counters
	// ************************************************************
	generate
		for (genvar i = 0; i < NUM_CNT; i++)
		begin : g_cnt
			logic [1:0] mode; // Mode in force

			assign mode = eff_mode(i, ctrl_q[i]);
			assign wr_ctrl[i] = bus.wr && bus.addr == ctrl_addr(i);
			assign wr_data[i] = bus.wr && bus.addr == ctrl_addr(i) + 4'h1;

			tevcg_prescale u_psc
			(
				.mclk(mclk),
				.reset_n(reset_n),
				.div(ctrl_q[i].div),
				.tick(tick[i])
			);

			// Count source per mode; a data write inhibits the clock
			always_comb
			begin
				inc[i] = 1'b0;
				if (ctrl_q[i].run && !wr_data[i])
				begin
					unique case (mode)
						MODE_TIMER:
							inc[i] = tick[i];
						MODE_EVENT:
							// No power-down gating on this path
							if (i == 0)
								inc[i] = ctrl_q[i].edge_sel ? ext_fall
									: ext_rise;
						MODE_PULSE:
							if (i == 0)
								inc[i] = pw_q == PW_MEASURE;
						MODE_ONESHOT:
							if (i == 1)
								inc[i] = tick[i];
					endcase
				end
			end

			assign ovf[i] = inc[i] && count_q[i] == COUNT_FULL;
			assign hw_set[i] = i == 1 && mode == MODE_ONESHOT
				&& pulse_generator_stop;
			assign hw_clr[i] = (i == 0 && pw_end)
				|| (i == 1 && mode == MODE_ONESHOT && ovf[i]);

			// Control register; software write wins over hardware
			always_ff @(posedge mclk)
			begin
				if (!reset_n)
					ctrl_q[i] <= CTRL_RESET;
				else if (wr_ctrl[i])
					ctrl_q[i] <= bus.wdata & ctrl_mask(i);
				else if (hw_set[i])
					ctrl_q[i].run <= 1'b1;
				else if (hw_clr[i])
					ctrl_q[i].run <= 1'b0;
			end

			// Preload register
			always_ff @(posedge mclk)
			begin
				if (!reset_n)
					preload_q[i] <= PRELOAD_RESET;
				else if (wr_data[i])
					preload_q[i] <= bus.wdata;
			end

			// Count: load, reload on overflow, or step; else hold
			always_ff @(posedge mclk)
			begin
				if (!reset_n)
					count_q[i] <= COUNT_RESET;
				else if (wr_data[i])
					count_q[i] <= bus.wdata;
				else if (ovf[i])
					count_q[i] <= preload_q[i];
				else if (inc[i])
					count_q[i] <= count_q[i] + 8'h01;
			end

			// Checks per counter
			chk_ovf_reload: assert property (ovf[i] |=>
				count_q[i] == $past(preload_q[i]))
				else $error("overflow did not reload from preload");
			chk_ovf_flag: assert property (ovf[i] |=> flag_q[i])
				else $error("overflow flag not raised");
			chk_data_load: assert property (wr_data[i] |=>
				count_q[i] == $past(bus.wdata)
				&& preload_q[i] == $past(bus.wdata))
				else $error("data write did not load both registers");
			chk_timer_step: assert property (mode == MODE_TIMER
				&& ctrl_q[i].run && tick[i] && !wr_data[i]
				&& count_q[i] != COUNT_FULL
				|=> count_q[i] == $past(count_q[i]) + 8'h01)
				else $error("timer missed a prescaled step");
			chk_run_hold: assert property (!ctrl_q[i].run
				&& !wr_data[i] |=> $stable(count_q[i]))
				else $error("disabled counter changed");
		end
	endgenerate

	// ************************************************************
	// Requests and wake-up
	// ************************************************************
	// Sticky flags; a new overflow beats a clear
	always_ff @(posedge mclk)
	begin
		if (!reset_n)
			flag_q <= '0;
		else
			flag_q <= ovf | (flag_q
				& ~({NUM_CNT{wr_flag}} & bus.wdata[NUM_CNT-1:0]));
	end

	// Interrupt enables
	always_ff @(posedge mclk)
	begin
		if (!reset_n)
			ien_q <= '0;
		else if (bus.wr && bus.addr == ADDR_IEN)
			ien_q <= bus.wdata[NUM_CNT-1:0];
	end

	// Wake-up regardless of enables
	always_ff @(posedge mclk)
	begin
		if (!reset_n)
			wake_q <= 1'b0;
		else
			wake_q <= |ovf;
	end

	assign irq_req = flag_q & ien_q;
	assign wake_up = wake_q;

	// ************************************************************
	// Read port
	// ************************************************************
	// Read data stands in the cycle after the strobe only
	always_ff @(posedge mclk)
	begin
		if (!reset_n)
			rdata_q <= 8'h00;
		else if (!bus.rd)
			rdata_q <= 8'h00;
		else
		begin
			unique case (bus.addr)
				4'h0, 4'h2, 4'h4:
					rdata_q <= ctrl_q[bus.addr[2:1]];
				4'h1, 4'h3, 4'h5:
					rdata_q <= count_q[bus.addr[2:1]];
				ADDR_FLAG:
					rdata_q <= {5'h00, flag_q};
				ADDR_IEN:
					rdata_q <= {5'h00, ien_q};
				default:
					rdata_q <= 8'h00;
			endcase
		end
	end

	assign rdata = rdata_q;

	// ************************************************************
	// Group checks
	// ************************************************************
	sequence s_pw_open;
		pw_start;
	endsequence

	sequence s_pw_close;
		pw_end && !wr_ctrl[0];
	endsequence

	chk_pw_open: assert property (s_pw_open |=>
		pw_q == PW_MEASURE)
		else $error("capture did not start on active edge");
	chk_pw_close: assert property (s_pw_close |=>
		!ctrl_q[0].run ##1 pw_q == PW_WAIT)
		else $error("capture end did not clear enable");
	chk_event_edge: assert property (ctrl_q[0].mode == MODE_EVENT
		&& ctrl_q[0].run && !wr_data[0] && count_q[0] != COUNT_FULL
		&& (ctrl_q[0].edge_sel ? ext_fall : ext_rise)
		|=> count_q[0] == $past(count_q[0]) + 8'h01)
		else $error("event counter missed an active edge");
	chk_oneshot_set: assert property (hw_set[1] && !wr_ctrl[1] |=>
		ctrl_q[1].run)
		else $error("generator stop did not enable counter 1");
	chk_oneshot_stop: assert property (ovf[1] && !hw_set[1]
		&& !wr_ctrl[1] && ctrl_q[1].mode == MODE_ONESHOT
		|=> !ctrl_q[1].run)
		else $error("one-shot overflow did not clear enable");
	chk_no_mode: assert property ((ctrl_q[1].mode == MODE_EVENT
		|| ctrl_q[1].mode == MODE_PULSE) && !wr_data[1]
		|=> $stable(count_q[1]))
		else $error("counter 1 counted in an empty mode");
	chk_timer_keep: assert property (ctrl_q[0].mode != MODE_PULSE
		&& ctrl_q[0].run && !wr_ctrl[0] |=> ctrl_q[0].run)
		else $error("enable cleared without software");
	chk_unused_zero: assert property (bus.rd && bus.addr == 4'h4
		|=> rdata[7:5] == 3'h0 && !rdata[3])
		else $error("unused control bits read nonzero");
	chk_irq_gate: assert property (|(ovf & ien_q)
		&& !(bus.wr && bus.addr == ADDR_IEN)
		|=> |(irq_req & $past(ovf)))
		else $error("enabled overflow gave no request");
	chk_wake: assert property (|ovf |=> wake_up ##1 !wake_up
		|| $past(|ovf))
		else $error("overflow did not give a wake-up pulse");

endmodule // tevcg_top
`default_nettype wire

// ===== tevcg_src_model.sv
`timescale 1ns/1ns
`default_nettype none
// ************************************************************
// Pin source: toggles the timer pin a set number of times
// ************************************************************
module tevcg_src_model
(
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic go,
	input wire logic [7:0] n_tog,
	input wire logic [7:0] gap,
	output logic pin,
	output logic busy
);
	logic [7:0] left_q; // Toggles still to make
	logic [7:0] wait_q; // Cycles to next toggle

	// Pin is a plain level: it holds its last value, as a real source does
	always_ff @(posedge mclk)
	begin
		if (!reset_n)
		begin
			pin <= 1'b0;
			left_q <= 8'h00;
			wait_q <= 8'h00;
		end
		else if (go)
		begin
			left_q <= n_tog;
			wait_q <= gap;
		end
		else if (left_q != 8'h00)
		begin
			if (wait_q <= 8'h01)
			begin
				pin <= ~pin;
				left_q <= left_q - 8'h01;
				wait_q <= gap;
			end
			else
				wait_q <= wait_q - 8'h01;
		end
	end

	assign busy = (left_q != 8'h00);
endmodule // tevcg_src_model
`default_nettype wire

// ===== tevcg_top_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tevcg_top_tb_top;
	import tevcg_pkg::*;
	logic mclk; // System clock
	logic reset_n; // Synchronous reset
	tevcg_bus_t bus; // Register port
	logic [7:0] rdata;
	logic pin; // Timer pin from source
	logic irq0_in; // Alternative source, low except for two pulses in t_irq0
	logic pg_stop; // Generator stop pulse
	logic [2:0] irq_req;
	logic wake_up;
	logic go;
	logic [7:0] n_tog;
	logic [7:0] gap;
	logic busy;
	int mismatches;
	int n_checks;
	int cycles;

	// ************************************************************
	// Instances
	// ************************************************************
	tevcg_top DUT (.mclk(mclk), .reset_n(reset_n), .bus(bus),
		.rdata(rdata), .counter0_input_pin(pin),
		.external_irq0_signal(irq0_in), .pulse_generator_stop(pg_stop),
		.irq_req(irq_req), .wake_up(wake_up));
	tevcg_src_model SRC (.mclk(mclk), .reset_n(reset_n), .go(go),
		.n_tog(n_tog), .gap(gap), .pin(pin), .busy(busy));

	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	// Hang guard
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 30000)
		begin
			mismatches++;
			report_and_stop();
		end
	end

	// ************************************************************
	// Shared tasks
	// ************************************************************
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		n_checks++;
		if (g !== e)
		begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge mclk);
		bus.wr <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, output logic [7:0] v);
		@(posedge mclk);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge mclk);
		bus.rd <= 1'b0;
		#1 v = rdata;
	endtask

	task automatic rchk(input logic [3:0] a, input logic [7:0] e);
		logic [7:0] v;
		rd(a, v);
		chk(v, e);
	endtask

	// Pin toggles from the source, waited for under a bound
	task automatic src(input logic [7:0] n, input logic [7:0] g);
		int k;
		@(posedge mclk);
		go <= 1'b1;
		n_tog <= n;
		gap <= g;
		@(posedge mclk);
		go <= 1'b0;
		@(posedge mclk);
		for (k = 0; k < 3000 && busy !== 1'b0; k++)
			@(posedge mclk);
		chk({7'h0, busy}, 8'h00);
		repeat (3) @(posedge mclk);
	endtask

	// ************************************************************
	// Scenarios
	// ************************************************************
	task automatic t_regs();
		int a;
		for (a = 0; a < 9; a++)
			rchk(a[3:0], 8'h00);
		wr(4'h0, 8'hff);
		wr(4'h2, 8'hff);
		wr(4'h4, 8'hff);
		wr(4'h8, 8'hff);
		rchk(4'h0, 8'hff);
		rchk(4'h2, 8'hd7);
		rchk(4'h4, 8'h17);
		rchk(4'h8, 8'h00);
		for (a = 0; a < 6; a += 2)
			wr(a[3:0], 8'h00);
		wr(4'h6, 8'h07);
		wr(4'h7, 8'h07);
	endtask

	// Counter 2 from preload fe overflows after two prescaled ticks
	task automatic t_timer(input logic [2:0] d);
		int c;
		logic woke;
		logic [7:0] v;
		woke = 1'b0;
		wr(4'h5, 8'hfe);
		rchk(4'h5, 8'hfe);
		wr(4'h4, 8'h10 | d);
		for (c = 0; c < 400 && irq_req[2] !== 1'b1; c++)
		begin
			@(posedge mclk);
			#1 woke |= (wake_up === 1'b1);
		end
		repeat (3)
		begin
			@(posedge mclk);
			#1 woke |= (wake_up === 1'b1);
		end
		chk({7'h0, c > (1 << d) && c <= (2 << d) + 4}, 8'h01);
		chk({7'h0, woke}, 8'h01);
		if (d == 3'h7)
			rchk(4'h5, 8'hfe);
		rchk(4'h4, 8'h10 | d);
		wr(4'h7, 8'h00);
		#1 chk({7'h0, irq_req[2]}, 8'h00);
		rd(4'h6, v);
		chk(v & 8'h04, 8'h04);
		wr(4'h7, 8'h07);
		wr(4'h4, 8'h00);
		wr(4'h5, 8'h33);
		repeat (20) @(posedge mclk);
		rchk(4'h5, 8'h33);
		wr(4'h6, 8'h07);
	endtask

	// Five toggles; counts rising or falling edges only
	task automatic t_event(input logic e);
		logic [7:0] rises;
		rises = (pin === 1'b0) ? 8'h03 : 8'h02;
		wr(4'h1, 8'h00);
		wr(4'h0, 8'h50 | {4'h0, e, 3'h7});
		src(8'h05, 8'h03);
		rchk(4'h1, e ? 8'h05 - rises : rises);
		rchk(4'h0, 8'h50 | {4'h0, e, 3'h7});
		wr(4'h0, 8'h00);
	endtask

	// Pulse of twenty cycles against the idle level
	task automatic t_pulse(input logic e);
		logic [7:0] v;
		if (pin !== !e)
			src(8'h01, 8'h01);
		wr(4'h1, 8'h00);
		wr(4'h0, 8'hd0 | {4'h0, e, 3'h0});
		repeat (10) @(posedge mclk);
		rchk(4'h1, 8'h00);
		src(8'h02, 8'h14);
		rd(4'h1, v);
		chk({7'h0, v >= 8'h13 && v <= 8'h15}, 8'h01);
		rchk(4'h0, 8'hc0 | {4'h0, e, 3'h0});
		src(8'h04, 8'h03);
		rchk(4'h1, v);
	endtask

	// Event counting from the irq0 signal; pin toggles ignored
	task automatic t_irq0();
		int k;
		wr(4'h1, 8'h00);
		wr(4'h0, 8'h70);
		for (k = 0; k < 2; k++)
		begin
			@(posedge mclk);
			irq0_in <= 1'b1;
			@(posedge mclk);
			irq0_in <= 1'b0;
		end
		src(8'h02, 8'h03);
		repeat (2) @(posedge mclk);
		rchk(4'h1, 8'h02);
		wr(4'h0, 8'h00);
	endtask

	// Generator stop starts counter 1; overflow stops it
	task automatic t_oneshot();
		int c;
		wr(4'h3, 8'hfe);
		repeat (10) @(posedge mclk);
		rchk(4'h3, 8'hfe);
		@(posedge mclk);
		pg_stop <= 1'b1;
		@(posedge mclk);
		pg_stop <= 1'b0;
		for (c = 0; c < 20 && irq_req[1] !== 1'b1; c++)
			@(posedge mclk);
		chk({7'h0, irq_req[1]}, 8'h01);
		rchk(4'h2, 8'h00);
		rchk(4'h3, 8'hfe);
		wr(4'h6, 8'h07);
	endtask

	// Codes 01 and 11 on counter 1 leave it still
	task automatic t_nomode();
		int i;
		logic [7:0] m;
		for (i = 0; i < 2; i++)
		begin
			m = i ? 8'hd0 : 8'h50;
			wr(4'h3, 8'h10);
			wr(4'h2, m);
			repeat (10) @(posedge mclk);
			rchk(4'h3, 8'h10);
			rchk(4'h2, m);
		end
		wr(4'h2, 8'h00);
	endtask

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial
	begin
		cycles = 0;
		mismatches = 0;
		n_checks = 0;
		reset_n = 1'b0;
		bus = '0;
		irq0_in = 1'b0;
		pg_stop = 1'b0;
		go = 1'b0;
		n_tog = 8'h00;
		gap = 8'h01;
		repeat (6) @(posedge mclk);
		reset_n <= 1'b1;
		t_regs();
		t_timer(3'h0);
		t_timer(3'h3);
		t_timer(3'h7);
		t_event(1'b0);
		t_event(1'b1);
		t_pulse(1'b0);
		t_pulse(1'b1);
		t_irq0();
		t_oneshot();
		t_nomode();
		report_and_stop();
	end
endmodule // tevcg_top_tb_top
`default_nettype wire
